// ---- core/system_option_and_lvd_regs.sv ----
// Purpose: system option, identification and supply monitor registers
// Assumes: plain register port, read data one cycle after strobe
// Notes: write-once bits lock on the first write after reset
// How it works
// - Clock select: 0 slow oscillator, 1 bus
// - Windowed service only in last quarter
// - Early service-register write forces reset
// - Write-once bits take only first write
// - Bit 2 enables port-one input filter
// - Bit 1 enables port-two input filter
// - Bit 0 routes comparator to capture
// - Read-only twelve-bit part number
// - Upper ident nibble reserved, writes ignored
// - Warning flag sets on low supply
// - Acknowledge clears flag once condition gone
// - Warning interrupt while flag and enable
// - Detect reset needs both enables set
// - Stop enable keeps detect in stop
// - Detect enable gates all detect bits
// - Bit 0 enables bandgap buffer
// - Timeout field; shortest window 6144 cycles
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`include "sysopt_defines.svh"
module system_option_and_lvd_regs (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Register port
    input wire logic [`ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // Supply monitor and modes
    input wire logic supply_warn_in,
    input wire logic supply_detect_in,
    input wire logic stop_mode_in,
    // Comparator path
    input wire logic comparator_in,
    output logic capture_ch0_out,
    // Controls to other blocks
    output sysopt_pkg::ctrl_s ctrl_out,
    output logic detect_active_out,
    output logic chip_reset_out,
    output logic irq_out
);
    sysopt_pkg::bus_req_s req;
    sysopt_pkg::service_e svc_q;
    logic wdog_clksel_q;
    logic wdog_window_q;
    logic [1:0] wdog_tsel_q;
    logic sp1_q;
    logic sp2_q;
    logic cmp_q;
    logic warn_flag_q;
    logic warn_ie_q;
    logic det_rst_q;
    logic det_stop_q;
    logic det_en_q;
    logic bandgap_q;
    logic opt_lock_q;
    logic pm_lock_q;
    logic wcfg_lock_q;
    logic [`IRQ_BITS-1:0] irq_stat_q;
    logic [`IRQ_BITS-1:0] irq_mask_q;
    logic warn_prev_q;
    logic [7:0] rdata_q;
    logic lpo_tick;
    logic win_open;
    logic wd_timeout;
    logic wd_restart;
    logic early_write;
    logic svc_write;
    logic [`IRQ_BITS-1:0] irq_events;
    logic warn_rise;
    // Reset words and part number as sized vectors, indexed per bit
    localparam logic [7:0] OPT_RST = `RST_SYSOPT2;
    localparam logic [7:0] PM_RST = `RST_PMCTRL1;
    localparam logic [11:0] PART = `PART_NUMBER;

    function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] o);
        return a == o;
    endfunction

    assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    lpo_divider u_lpo (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .tick_out(lpo_tick)
    );

    wdog_timer u_wdog (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .timeout_sel_in(wdog_tsel_q),
        .clk_sel_in(wdog_clksel_q),
        .lpo_tick_in(lpo_tick),
        .restart_in(wd_restart),
        .window_open_out(win_open),
        .timeout_out(wd_timeout)
    );

    // Option register
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            opt_lock_q <= 1'b0;
            wdog_clksel_q <= OPT_RST[`B_WDOG_CLKSEL];
            wdog_window_q <= OPT_RST[`B_WDOG_WINDOW];
            sp1_q <= OPT_RST[`B_SP1_FILTER];
            sp2_q <= OPT_RST[`B_SP2_FILTER];
            cmp_q <= OPT_RST[`B_CMP_CAPTURE];
        end else if (req.wr && hit(req.addr, `OFF_SYSOPT2)) begin
            if (!opt_lock_q) begin
                wdog_clksel_q <= req.wdata[`B_WDOG_CLKSEL];
                wdog_window_q <= req.wdata[`B_WDOG_WINDOW];
                opt_lock_q <= 1'b1;
            end
            sp1_q <= req.wdata[`B_SP1_FILTER];
            sp2_q <= req.wdata[`B_SP2_FILTER];
            cmp_q <= req.wdata[`B_CMP_CAPTURE];
        end
    end

    // Watchdog timeout field, write-once
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            wcfg_lock_q <= 1'b0;
            wdog_tsel_q <= `RST_WDOG_CFG;
        end else if (req.wr && hit(req.addr, `OFF_WDOG_CFG) && !wcfg_lock_q) begin
            wdog_tsel_q <= req.wdata[1:0];
            wcfg_lock_q <= 1'b1;
        end
    end

    // Power management register controls
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            pm_lock_q <= 1'b0;
            warn_ie_q <= PM_RST[`B_WARN_IRQ_EN];
            det_rst_q <= PM_RST[`B_DET_RESET_EN];
            det_stop_q <= PM_RST[`B_DET_STOP_EN];
            det_en_q <= PM_RST[`B_DET_EN];
            bandgap_q <= PM_RST[`B_BANDGAP_EN];
        end else if (req.wr && hit(req.addr, `OFF_PMCTRL1)) begin
            if (!pm_lock_q) begin
                det_rst_q <= req.wdata[`B_DET_RESET_EN];
                det_en_q <= req.wdata[`B_DET_EN];
                pm_lock_q <= 1'b1;
            end
            warn_ie_q <= req.wdata[`B_WARN_IRQ_EN];
            det_stop_q <= req.wdata[`B_DET_STOP_EN];
            bandgap_q <= req.wdata[`B_BANDGAP_EN];
        end
    end

    // Warning flag: set wins over acknowledge
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            warn_flag_q <= 1'b0;
        end else if (supply_warn_in) begin
            warn_flag_q <= 1'b1;
        end else if (req.wr && hit(req.addr, `OFF_PMCTRL1) && req.wdata[`B_WARN_ACK]) begin
            warn_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            warn_prev_q <= 1'b0;
        end else begin
            warn_prev_q <= warn_flag_q;
        end
    end
    assign warn_rise = warn_flag_q && !warn_prev_q;

    // Service sequence on the reset status register
    assign svc_write = req.wr && hit(req.addr, `OFF_RESET_STATUS);
    assign early_write = svc_write && wdog_window_q && !win_open && (wdog_tsel_q != 2'b00);

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            svc_q <= sysopt_pkg::WD_IDLE;
        end else if (svc_write) begin
            case (svc_q)
                sysopt_pkg::WD_IDLE: begin
                    if (req.wdata == `SERVICE_FIRST) begin
                        svc_q <= sysopt_pkg::WD_GOT_FIRST;
                    end
                end
                sysopt_pkg::WD_GOT_FIRST: begin
                    svc_q <= sysopt_pkg::WD_IDLE;
                end
                default: begin
                    svc_q <= sysopt_pkg::WD_IDLE;
                end
            endcase
        end
    end

    assign wd_restart = svc_write && svc_q == sysopt_pkg::WD_GOT_FIRST
        && req.wdata == `SERVICE_SECOND && (!wdog_window_q || win_open);

    // Interrupt status and mask
    assign irq_events = {early_write, wd_timeout, warn_rise};
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            irq_stat_q <= '0;
        end else if (req.wr && hit(req.addr, `OFF_IRQ_STATUS)) begin
            irq_stat_q <= (irq_stat_q & ~req.wdata[`IRQ_BITS-1:0]) | irq_events;
        end else begin
            irq_stat_q <= irq_stat_q | irq_events;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            irq_mask_q <= '0;
        end else if (req.wr && hit(req.addr, `OFF_IRQ_MASK)) begin
            irq_mask_q <= req.wdata[`IRQ_BITS-1:0];
        end
    end
    assign irq_out = (|(irq_stat_q & irq_mask_q)) || (warn_ie_q && warn_flag_q);

    // Read data
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rdata_q <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                `OFF_SYSOPT2: rdata_q <= {wdog_clksel_q, wdog_window_q, 3'b000,
                    sp1_q, sp2_q, cmp_q};
                `OFF_IDENT_HI: rdata_q <= {4'h0, PART[11:8]};
                `OFF_IDENT_LO: rdata_q <= PART[7:0];
                `OFF_PMCTRL1: rdata_q <= {warn_flag_q, 1'b0, warn_ie_q, det_rst_q,
                    det_stop_q, det_en_q, 1'b0, bandgap_q};
                `OFF_IRQ_STATUS: rdata_q <= {5'h00, irq_stat_q};
                `OFF_IRQ_MASK: rdata_q <= {5'h00, irq_mask_q};
                `OFF_WDOG_CFG: rdata_q <= {6'h00, wdog_tsel_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign rdata_out = rdata_q;

    assign ctrl_out = '{sp1_filter: sp1_q, sp2_filter: sp2_q, cmp_capture: cmp_q,
        bandgap_en: bandgap_q, det_en: det_en_q, det_stop_en: det_stop_q};
    assign capture_ch0_out = cmp_q & comparator_in;
    assign detect_active_out = det_en_q && (!stop_mode_in || det_stop_q);
    assign chip_reset_out = (detect_active_out && det_rst_q && supply_detect_in)
        || early_write || wd_timeout;
endmodule

// ---- core/sysopt_defines.svh ----
`ifndef SYSOPT_DEFINES_SVH
`define SYSOPT_DEFINES_SVH
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 8-bit register port, byte offsets chosen locally
// Notes: identity value is arbitrary
`define ADDR_W 4
`define OFF_SYSOPT2 4'h0
`define OFF_IDENT_HI 4'h1
`define OFF_IDENT_LO 4'h2
`define OFF_PMCTRL1 4'h3
`define OFF_RESET_STATUS 4'h4
`define OFF_IRQ_STATUS 4'h5
`define OFF_IRQ_MASK 4'h6
`define OFF_WDOG_CFG 4'h7
// Option register bits
`define B_WDOG_CLKSEL 7
`define B_WDOG_WINDOW 6
`define B_SP1_FILTER 2
`define B_SP2_FILTER 1
`define B_CMP_CAPTURE 0
// Power management bits
`define B_WARN_FLAG 7
`define B_WARN_ACK 6
`define B_WARN_IRQ_EN 5
`define B_DET_RESET_EN 4
`define B_DET_STOP_EN 3
`define B_DET_EN 2
`define B_BANDGAP_EN 0
// Reset values
`define RST_SYSOPT2 8'h00
`define RST_PMCTRL1 8'h1C
`define RST_WDOG_CFG 2'h3
// Part number, arbitrary neutral value
`define PART_NUMBER 12'h5A3
`define SERVICE_FIRST 8'h55
`define SERVICE_SECOND 8'hAA
// Status bits: 0 warning set, 1 watchdog timeout, 2 window violation
`define IRQ_BITS 3
// Clock and slow oscillator
`define CLK_HZ 50000000
`define LPO_HZ 1000
`define LPO_DIV (`CLK_HZ / `LPO_HZ)
`define WIN_OPEN_SHORT 6144
`endif

// ---- core/sysopt_pkg.sv ----
// Purpose: types for the system option block
// Assumes: constants live in sysopt_defines.svh
// Notes: none
package sysopt_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;
    typedef struct packed {
        logic sp1_filter;
        logic sp2_filter;
        logic cmp_capture;
        logic bandgap_en;
        logic det_en;
        logic det_stop_en;
    } ctrl_s;
    typedef enum logic [1:0] {
        WD_IDLE,
        WD_GOT_FIRST
    } service_e;
endpackage

// ---- core/lpo_divider.sv ----
// Purpose: one-cycle enable at the slow oscillator rate
// Assumes: single clock
// Notes: stands in for the 1 kHz oscillator
`include "sysopt_defines.svh"
module lpo_divider #(
    parameter int DIV = `LPO_DIV
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Enable
    output logic tick_out
);
    logic [31:0] cnt_q;
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cnt_q <= 32'h0;
            tick_out <= 1'b0;
        end else if (cnt_q == 32'(DIV - 1)) begin
            cnt_q <= 32'h0;
            tick_out <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            tick_out <= 1'b0;
        end
    end
endmodule

// ---- core/wdog_timer.sv ----
// Purpose: watchdog counter with optional service window
// Assumes: counter cleared by restart pulse
// Notes: window opens at three quarters of the timeout
`include "sysopt_defines.svh"
module wdog_timer (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Control
    input wire logic [1:0] timeout_sel_in,
    input wire logic clk_sel_in,
    input wire logic lpo_tick_in,
    input wire logic restart_in,
    // Status
    output logic window_open_out,
    output logic timeout_out
);
    logic [18:0] cnt_q;
    logic [18:0] limit;
    logic step;
    function automatic logic [18:0] limit_of(input logic cs, input logic [1:0] t);
        logic [18:0] r;
        r = 19'h0;
        case ({cs, t})
            3'b001: r = 19'h00020;
            3'b010: r = 19'h00100;
            3'b011: r = 19'h00400;
            3'b101: r = 19'h02000;
            3'b110: r = 19'h10000;
            3'b111: r = 19'h40000;
            default: r = 19'h0;
        endcase
        return r;
    endfunction
    assign limit = limit_of(clk_sel_in, timeout_sel_in);
    assign step = clk_sel_in ? 1'b1 : lpo_tick_in;
    assign window_open_out = cnt_q >= (limit - (limit >> 2));
    always_ff @(posedge clk_in) begin
        if (!reset_n_in || restart_in || timeout_sel_in == 2'b00) begin
            cnt_q <= 19'h0;
            timeout_out <= 1'b0;
        end else if (step) begin
            if (cnt_q >= limit - 19'h1) begin
                cnt_q <= 19'h0;
                timeout_out <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 19'h1;
                timeout_out <= 1'b0;
            end
        end else begin
            timeout_out <= 1'b0;
        end
    end
endmodule

// ---- bench/sysopt_asserts.sv ----
// Purpose: port checks of the option and supply register block
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the bench top file
`include "sysopt_defines.svh"
module sysopt_asserts (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Register port
    input wire logic [`ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    // Modes and controls
    input wire logic stop_mode_in,
    input wire logic comparator_in,
    input wire logic capture_ch0_out,
    input wire sysopt_pkg::ctrl_s ctrl_out,
    input wire logic detect_active_out
);
    localparam logic [11:0] PART = `PART_NUMBER;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    ident_low_a: assert property (
        $past(rd_in) && $past(addr_in) == `OFF_IDENT_LO |-> rdata_out == PART[7:0])
        else $error("part number low byte wrong");
    ident_high_a: assert property (
        $past(rd_in) && $past(addr_in) == `OFF_IDENT_HI |-> rdata_out == {4'h0, PART[11:8]})
        else $error("part number high byte wrong");
    capture_route_a: assert property (
        capture_ch0_out == (comparator_in && ctrl_out.cmp_capture))
        else $error("comparator route wrong");
    detect_active_a: assert property (
        detect_active_out == (ctrl_out.det_en && (!stop_mode_in || ctrl_out.det_stop_en)))
        else $error("detect activity wrong");
    detect_lock_a: assert property (
        !ctrl_out.det_en |=> !ctrl_out.det_en)
        else $error("locked detect enable changed");
    port_filter_a: assert property (
        wr_in && addr_in == `OFF_SYSOPT2 |=> ctrl_out.sp1_filter == $past(wdata_in[2]))
        else $error("port one filter not written");
    filter_capture_a: assert property (
        wr_in && addr_in == `OFF_SYSOPT2 |=>
        {ctrl_out.sp2_filter, ctrl_out.cmp_capture} == $past(wdata_in[1:0]))
        else $error("port two filter or capture not written");
    bandgap_write_a: assert property (
        wr_in && addr_in == `OFF_PMCTRL1 |=> ctrl_out.bandgap_en == $past(wdata_in[0]))
        else $error("bandgap enable not written");
    cover property (wr_in && addr_in == `OFF_RESET_STATUS);
    cover property (stop_mode_in && detect_active_out);
    cover property (!ctrl_out.det_en);
endmodule

// ---- bench/system_option_and_lvd_regs_bench.sv ----
// Purpose: directed bench for the option and supply register block
// Assumes: 50 MHz clock, watchdog run from the bus clock
// Notes: chip reset output is counted, not fed back
`include "sysopt_defines.svh"
module system_option_and_lvd_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] PART = `PART_NUMBER;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic supply_warn_in = 1'b0;
    logic supply_detect_in = 1'b0;
    logic stop_mode_in = 1'b0;
    logic comparator_in = 1'b0;
    logic [7:0] rdata_out;
    logic capture_ch0_out;
    sysopt_pkg::ctrl_s ctrl_out;
    logic detect_active_out;
    logic chip_reset_out;
    logic irq_out;
    int n_mismatch = 0;
    int checks = 0;
    int n_rst = 0;
    int base = 0;
    system_option_and_lvd_regs i_dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .supply_warn_in(supply_warn_in),
        .supply_detect_in(supply_detect_in), .stop_mode_in(stop_mode_in),
        .comparator_in(comparator_in), .capture_ch0_out(capture_ch0_out),
        .ctrl_out(ctrl_out), .detect_active_out(detect_active_out),
        .chip_reset_out(chip_reset_out), .irq_out(irq_out)
    );
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    // Chip reset may be a one-cycle pulse
    always @(posedge clk_in) begin
        if (chip_reset_out === 1'b1) begin
            n_rst <= n_rst + 1;
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
        @(posedge clk_in);
    endtask
    task automatic do_reset();
        reset_n_in <= 1'b0;
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
    endtask
    initial begin
        repeat (40000) @(posedge clk_in);
        n_mismatch++;
        complete_run();
    end
    initial begin
        do_reset();
        chk({2'h0, ctrl_out}, 8'h03);
        rchk(`OFF_SYSOPT2, 8'h00);
        rchk(`OFF_IDENT_HI, {4'h0, PART[11:8]});
        rchk(`OFF_IDENT_LO, PART[7:0]);
        wr(`OFF_IDENT_HI, 8'hFF);
        rchk(`OFF_IDENT_HI, {4'h0, PART[11:8]});
        wr(4'hF, 8'hFF);
        rchk(4'hF, 8'h00);
        wr(`OFF_WDOG_CFG, 8'h01);
        wr(`OFF_SYSOPT2, 8'hC7);
        comparator_in <= 1'b1;
        rchk(`OFF_SYSOPT2, 8'hC7);
        chk({2'h0, ctrl_out}, 8'h3B);
        chk({7'h0, capture_ch0_out}, 8'h01);
        wr(`OFF_SYSOPT2, 8'h00);
        rchk(`OFF_SYSOPT2, 8'hC0);
        chk({7'h0, capture_ch0_out}, 8'h00);
        chk({2'h0, ctrl_out}, 8'h03);
        wr(`OFF_WDOG_CFG, 8'h02);
        rchk(`OFF_WDOG_CFG, 8'h01);
        base = n_rst;
        wr(`OFF_RESET_STATUS, `SERVICE_FIRST);
        repeat (3) @(posedge clk_in);
        chk({7'h0, n_rst > base}, 8'h01);
        rchk(`OFF_IRQ_STATUS, 8'h04);
        chk({7'h0, irq_out}, 8'h00);
        wr(`OFF_IRQ_MASK, 8'h04);
        chk({7'h0, irq_out}, 8'h01);
        wr(`OFF_IRQ_STATUS, 8'h04);
        chk({7'h0, irq_out}, 8'h00);
        wr(`OFF_PMCTRL1, 8'h1D);
        rchk(`OFF_PMCTRL1, 8'h1D);
        stop_mode_in <= 1'b1;
        @(posedge clk_in);
        chk({7'h0, detect_active_out}, 8'h01);
        wr(`OFF_PMCTRL1, 8'h14);
        chk({7'h0, detect_active_out}, 8'h00);
        stop_mode_in <= 1'b0;
        supply_detect_in <= 1'b1;
        @(posedge clk_in);
        chk({6'h0, detect_active_out, chip_reset_out}, 8'h03);
        supply_detect_in <= 1'b0;
        wr(`OFF_PMCTRL1, 8'h00);
        rchk(`OFF_PMCTRL1, 8'h14);
        supply_warn_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        wr(`OFF_PMCTRL1, 8'h74);
        rchk(`OFF_PMCTRL1, 8'hB4);
        chk({7'h0, irq_out}, 8'h01);
        supply_warn_in <= 1'b0;
        wr(`OFF_PMCTRL1, 8'h74);
        rchk(`OFF_PMCTRL1, 8'h34);
        chk({7'h0, irq_out}, 8'h00);
        rchk(`OFF_IRQ_STATUS, 8'h01);
        supply_warn_in <= 1'b1;
        do_reset();
        supply_warn_in <= 1'b0;
        rchk(`OFF_PMCTRL1, 8'h9C);
        wr(`OFF_PMCTRL1, 8'h48);
        rchk(`OFF_PMCTRL1, 8'h08);
        supply_detect_in <= 1'b1;
        @(posedge clk_in);
        chk({6'h0, detect_active_out, chip_reset_out}, 8'h00);
        supply_detect_in <= 1'b0;
        wr(`OFF_PMCTRL1, 8'h1C);
        rchk(`OFF_PMCTRL1, 8'h08);
        wr(`OFF_IRQ_STATUS, 8'h07);
        wr(`OFF_WDOG_CFG, 8'h01);
        wr(`OFF_SYSOPT2, 8'hC0);
        base = n_rst;
        repeat (6300) @(posedge clk_in);
        wr(`OFF_RESET_STATUS, `SERVICE_FIRST);
        wr(`OFF_RESET_STATUS, `SERVICE_SECOND);
        repeat (3) @(posedge clk_in);
        chk({7'h0, n_rst != base}, 8'h00);
        repeat (8300) @(posedge clk_in);
        chk({7'h0, n_rst != base}, 8'h01);
        rchk(`OFF_IRQ_STATUS, 8'h02);
        complete_run();
    end
endmodule
bind system_option_and_lvd_regs sysopt_asserts i_chk (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .stop_mode_in(stop_mode_in),
    .comparator_in(comparator_in), .capture_ch0_out(capture_ch0_out),
    .ctrl_out(ctrl_out), .detect_active_out(detect_active_out)
);
